// *** gph_port_cfg.sv ***
// Port H pin configuration and port I register block with pin control.
// Assumes an APB master on pclk; pins are resolved outside from the
// output, enable and pull controls given here.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module gph_port_cfg #(
  parameter int NH = gph_pkg::PH_PINS,
  parameter int NI = gph_pkg::PI_PINS,
  parameter int NQ = gph_pkg::IRQ_LINES
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [gph_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [gph_pkg::DATA_W-1:0]    pwdata,
  output logic      [gph_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          stop_mode,
  input  wire logic                          standby_pin_drive_keep,
  input  wire logic [NH-1:0]                 ph_pin_in,
  output logic      [NH-1:0]                 ph_drain_sel,
  output logic      [NH-1:0]                 ph_pullup,
  output logic      [NH-1:0]                 ph_pulldown,
  output logic      [NH-1:0]                 ph_input_gate,
  output logic      [NQ-1:0]                 ext_irq_line,
  input  wire logic [NI-1:0]                 pi_pin_in,
  output logic      [NI-1:0]                 pi_pin_out,
  output logic      [NI-1:0]                 pi_pin_oe,
  output logic      [NI-1:0]                 pi_pullup,
  output logic      [NI-1:0]                 pi_pulldown,
  output logic      [NI-1:0]                 pi_analog
);
  import gph_pkg::*;

  // Address match on a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a == off);
  endfunction : hit

  // Zero-extend a narrow field to the bus width
  function automatic logic [DATA_W-1:0] ext8(input logic [7:0] v);
    ext8 = {{(DATA_W-8){1'b0}}, v};
  endfunction : ext8

  logic [NQ-1:0] ph_fsel;
  logic [NH-1:0] ph_od;
  logic [NH-1:0] ph_pu;
  logic [NH-1:0] ph_pd;
  logic [NH-1:0] ph_ie;
  logic [NI-1:0] pi_val;
  logic [NI-1:0] pi_oe;
  logic [NI-1:0] pi_od;
  logic [NI-1:0] pi_pu;
  logic [NI-1:0] pi_pd;
  logic [NI-1:0] pi_ie;
  logic          wr;
  logic          rd_setup;
  logic          mapped;
  logic          drive_off;
  logic [DATA_W-1:0] next_rdata;
  logic [NI-1:0] pi_seen;

  // Bus strobes; every access completes in its first access cycle
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign mapped   = hit(paddr, OFF_PI_VALUE) | hit(paddr, OFF_PI_OE)
                  | hit(paddr, OFF_PI_OD) | hit(paddr, OFF_PI_PU)
                  | hit(paddr, OFF_PI_PD) | hit(paddr, OFF_PI_IE)
                  | hit(paddr, OFF_PH_FSEL) | hit(paddr, OFF_PH_OD)
                  | hit(paddr, OFF_PH_PU) | hit(paddr, OFF_PH_PD)
                  | hit(paddr, OFF_PH_IE);
  assign pslverr  = psel & penable & ~mapped;

  // Port H function select, only the low bits are stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ph_fsel <= RST_CFG[NQ-1:0];
    else if (wr && hit(paddr, OFF_PH_FSEL))
      ph_fsel <= pwdata[NQ-1:0];
  end

  // Port H drain, pull and input configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_od <= RST_CFG[NH-1:0];
      ph_pu <= RST_CFG[NH-1:0];
      ph_pd <= RST_CFG[NH-1:0];
      ph_ie <= RST_CFG[NH-1:0];
    end
    else if (wr)
    begin
      if (hit(paddr, OFF_PH_OD))
        ph_od <= pwdata[NH-1:0];
      if (hit(paddr, OFF_PH_PU))
        ph_pu <= pwdata[NH-1:0];
      if (hit(paddr, OFF_PH_PD))
        ph_pd <= pwdata[NH-1:0];
      if (hit(paddr, OFF_PH_IE))
        ph_ie <= pwdata[NH-1:0];
    end
  end

  // Port I data and direction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pi_val <= RST_CFG[NI-1:0];
      pi_oe  <= RST_CFG[NI-1:0];
    end
    else if (wr)
    begin
      if (hit(paddr, OFF_PI_VALUE))
        pi_val <= pwdata[NI-1:0];
      if (hit(paddr, OFF_PI_OE))
        pi_oe <= pwdata[NI-1:0];
    end
  end

  // Port I drain, pull and input configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pi_od <= RST_CFG[NI-1:0];
      pi_pu <= RST_CFG[NI-1:0];
      pi_pd <= RST_CFG[NI-1:0];
      pi_ie <= RST_CFG[NI-1:0];
    end
    else if (wr)
    begin
      if (hit(paddr, OFF_PI_OD))
        pi_od <= pwdata[NI-1:0];
      if (hit(paddr, OFF_PI_PU))
        pi_pu <= pwdata[NI-1:0];
      if (hit(paddr, OFF_PI_PD))
        pi_pd <= pwdata[NI-1:0];
      if (hit(paddr, OFF_PI_IE))
        pi_ie <= pwdata[NI-1:0];
    end
  end

  // Value readback: driven bits show the latch, inputs the gated pin
  assign pi_seen = (pi_oe & pi_val) | (~pi_oe & pi_ie & pi_pin_in);

  // Read mux; upper bits always zero, unmapped reads zero
  always_comb
  begin
    next_rdata = RD_ZERO;
    unique case (1'b1)
      hit(paddr, OFF_PI_VALUE): next_rdata = ext8(8'(pi_seen));
      hit(paddr, OFF_PI_OE):    next_rdata = ext8(8'(pi_oe));
      hit(paddr, OFF_PI_OD):    next_rdata = ext8(8'(pi_od));
      hit(paddr, OFF_PI_PU):    next_rdata = ext8(8'(pi_pu));
      hit(paddr, OFF_PI_PD):    next_rdata = ext8(8'(pi_pd));
      hit(paddr, OFF_PI_IE):    next_rdata = ext8(8'(pi_ie));
      hit(paddr, OFF_PH_FSEL):  next_rdata = ext8(8'(ph_fsel));
      hit(paddr, OFF_PH_OD):    next_rdata = ext8(8'(ph_od));
      hit(paddr, OFF_PH_PU):    next_rdata = ext8(8'(ph_pu));
      hit(paddr, OFF_PH_PD):    next_rdata = ext8(8'(ph_pd));
      hit(paddr, OFF_PH_IE):    next_rdata = ext8(8'(ph_ie));
      default:                  next_rdata = RD_ZERO;
    endcase
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= RD_ZERO;
    else if (rd_setup)
      prdata <= next_rdata;
  end

  // Port H pad controls straight from configuration
  assign ph_drain_sel  = ph_od;
  assign ph_pullup     = ph_pu;
  assign ph_pulldown   = ph_pd;
  assign ph_input_gate = ph_ie;

  // Port I pins stop driving in stop mode unless drive is kept
  assign drive_off = stop_mode & ~standby_pin_drive_keep;

  // External interrupt lines from port H pins
  genvar q;
  generate
    for (q = 0; q < NQ; q++)
    begin : g_irq
      // Enable alone arms it when running; stop also needs the select
      assign ext_irq_line[q] = ph_ie[q] & ph_pin_in[q]
                             & (~stop_mode | ph_fsel[q]);
    end
  endgenerate

  // Port I pad drive: open-drain drives only a low
  genvar i;
  generate
    for (i = 0; i < NI; i++)
    begin : g_pi
      assign pi_pin_out[i]  = pi_val[i];
      assign pi_pin_oe[i]   = pi_oe[i] & ~drive_off
                            & ~(pi_od[i] & pi_val[i]);
      assign pi_pullup[i]   = pi_pu[i] & ~drive_off;
      assign pi_pulldown[i] = pi_pd[i] & ~drive_off;
      assign pi_analog[i]   = pi_pin_in[i];
    end
  endgenerate

  // Checks
  AST_FSEL_RESET:
  assert property (@(posedge pclk) $rose(presetn) |-> ph_fsel == '0)
    else $error("function select not cleared by reset");

  AST_FSEL_WRITE:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFF_PH_FSEL) |=> ph_fsel == $past(pwdata[NQ-1:0]))
    else $error("function select write lost");

  AST_OD_WRITE:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFF_PH_OD) |=> ph_drain_sel == $past(pwdata[7:0]))
    else $error("port H drain select write lost");

  AST_PU_HOLD:
  assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, OFF_PH_PU)) |=> $stable(ph_pullup))
    else $error("port H pull-up changed without write");

  AST_PD_WRITE:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFF_PH_PD) |=> ph_pulldown == $past(pwdata[7:0]))
    else $error("port H pull-down write lost");

  AST_IE_WRITE:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFF_PH_IE) ##1 !wr |=> ph_input_gate
      == $past(pwdata[7:0], 2))
    else $error("port H input enable write lost");

  AST_PI_DIR:
  assert property (@(posedge pclk) disable iff (!presetn)
    (pi_pin_oe & ~pi_oe) == '0)
    else $error("port I pin driven while set as input");

  AST_PI_ANALOG:
  assert property (@(posedge pclk) disable iff (!presetn)
    pi_analog == pi_pin_in)
    else $error("port I analog path not following pin");

  AST_PI_RESET:
  assert property (@(posedge pclk) $rose(presetn) |->
    pi_pin_oe == '0 && pi_pullup == '0 && pi_pulldown == '0)
    else $error("port I not disabled after reset");

  AST_PI_READ:
  assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit(paddr, OFF_PI_IE) ##1 penable |->
      prdata == ext8(8'(pi_ie)))
    else $error("port I input enable read wrong");

  AST_IRQ_RUN:
  assert property (@(posedge pclk) disable iff (!presetn)
    !stop_mode && ph_ie[0] && ph_pin_in[0] |-> ext_irq_line[0])
    else $error("interrupt not armed by input enable");

  AST_IRQ_STOP:
  assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode && ph_fsel[0] && ph_ie[0] && ph_pin_in[0]
      |-> ext_irq_line[0])
    else $error("wake interrupt lost in stop mode");

  AST_UPPER_ZERO:
  assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite |-> prdata[DATA_W-1:8] == '0)
    else $error("upper read bits not zero");

  // Configuration holds between writes and pull-up writes land; unmapped writes touch nothing
  AST_FSEL_HOLD:
  assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, OFF_PH_FSEL)) |=> $stable(ph_fsel))
    else $error("function select changed without write");

  AST_OD_HOLD:
  assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, OFF_PH_OD)) |=> $stable(ph_drain_sel))
    else $error("port H drain select changed without write");

  AST_PU_WRITE:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFF_PH_PU) |=> ph_pullup == $past(pwdata[NH-1:0]))
    else $error("port H pull-up write lost");

  AST_PD_HOLD:
  assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, OFF_PH_PD)) |=> $stable(ph_pulldown))
    else $error("port H pull-down changed without write");

  AST_IE_HOLD:
  assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, OFF_PH_IE)) |=> $stable(ph_input_gate))
    else $error("port H input enable changed without write");

  AST_UNMAPPED_KEEP:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && !mapped |=> $stable(ph_fsel) && $stable(ph_od) && $stable(pi_oe))
    else $error("unmapped write changed a register");

  // Interrupt gating by enable and, in stop, by function select
  AST_IRQ_GATED:
  assert property (@(posedge pclk) disable iff (!presetn)
    (ext_irq_line & ~ph_ie[NQ-1:0]) == '0)
    else $error("interrupt raised with input disabled");

  AST_IRQ_STOP_SEL:
  assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode |-> (ext_irq_line & ~ph_fsel) == '0)
    else $error("unselected interrupt active in stop mode");

  // Port I direction, open-drain and stop-mode drive
  AST_PI_OE_WRITE:
  assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, OFF_PI_OE) |=> pi_oe == $past(pwdata[NI-1:0]))
    else $error("port I direction write lost");

  AST_PI_OD_LOW:
  assert property (@(posedge pclk) disable iff (!presetn)
    (pi_pin_oe & pi_od & pi_val) == '0)
    else $error("open-drain port I pin driven high");

  AST_PI_CFG_RESET:
  assert property (@(posedge pclk) $rose(presetn) |->
    pi_ie == '0 && pi_od == '0 && pi_val == '0)
    else $error("port I configuration not cleared by reset");

  AST_PI_STOP_OFF:
  assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode && !standby_pin_drive_keep |->
      pi_pin_oe == '0 && pi_pullup == '0 && pi_pulldown == '0)
    else $error("port I still driven in stop mode");

  AST_UNMAPPED_READ:
  assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && !mapped |-> prdata == '0 && pslverr)
    else $error("unmapped read not refused");

endmodule : gph_port_cfg

// *** gph_pkg.sv ***
// Constants for the port H configuration and port I register block.
// Assumes a 32-bit APB slave clocked by pclk with presetn.
// Notes on behaviour
// - H function bits 2..0 select interrupt lines
// - H drain bits pick push-pull or open-drain
// - H pull-up bits enable pull-ups, reset off
// - H pull-down bits enable pull-downs, reset off
// - H input-enable bits gate pin input paths
// - Port I: four pins, per-bit direction
// - Port I pins also feed the converter
// - Port I resets to all paths but the converter feed disabled
// - Port I registers at six fixed offsets
// - Outside stop, input enable arms interrupt
// - Function plus enable wakes from stop
package gph_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  // Port I offsets
  localparam logic [7:0]  OFF_PI_VALUE = 8'h00;
  localparam logic [7:0]  OFF_PI_OE    = 8'h04;
  localparam logic [7:0]  OFF_PI_OD    = 8'h28;
  localparam logic [7:0]  OFF_PI_PU    = 8'h2c;
  localparam logic [7:0]  OFF_PI_PD    = 8'h30;
  localparam logic [7:0]  OFF_PI_IE    = 8'h38;
  // Port H configuration offsets
  localparam logic [7:0]  OFF_PH_FSEL  = 8'h48;
  localparam logic [7:0]  OFF_PH_OD    = 8'h68;
  localparam logic [7:0]  OFF_PH_PU    = 8'h6c;
  localparam logic [7:0]  OFF_PH_PD    = 8'h70;
  localparam logic [7:0]  OFF_PH_IE    = 8'h78;
  // Field widths and reset values
  localparam int          PH_PINS      = 8;
  localparam int          PI_PINS      = 4;
  localparam int          IRQ_LINES    = 3;
  localparam logic [7:0]  RST_CFG      = 8'h00;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage : gph_pkg

// *** gph_pin_model.sv ***
// Package pin model for port H and port I.
// Assumes the bench sets the external levels and their enables.
`timescale 1ns/10ps
module gph_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] h_ext,
  input  wire logic [7:0] h_ext_en,
  input  wire logic [7:0] h_pu,
  input  wire logic [7:0] h_pd,
  input  wire logic [3:0] i_ext,
  input  wire logic [3:0] i_ext_en,
  input  wire logic [3:0] i_out,
  input  wire logic [3:0] i_oe,
  input  wire logic [3:0] i_pu,
  input  wire logic [3:0] i_pd,
  output logic      [7:0] h_pin,
  output logic      [3:0] i_pin
);
  logic flt = 1'b0;
  // Undriven pins wander every cycle
  always @(posedge pclk) flt <= ~flt;
  // Resolve each pin: driver first, then pulls
  always_comb
  begin
    for (int k = 0; k < 8; k++)
      h_pin[k] = h_ext_en[k] ? h_ext[k] :
                 h_pu[k] ? 1'b1 : h_pd[k] ? 1'b0 : flt;
    for (int k = 0; k < 4; k++)
      i_pin[k] = i_oe[k] ? i_out[k] : i_ext_en[k] ? i_ext[k] :
                 i_pu[k] ? 1'b1 : i_pd[k] ? 1'b0 : flt;
  end
endmodule : gph_pin_model

// *** testbench.sv ***
// Self-checking bench for the port H/I configuration block.
// Assumes an APB master here and the pin model on the far side.
`timescale 1ns/10ps
module testbench;
  import gph_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stop_mode;
  logic        standby_pin_drive_keep, pready, pslverr, err;
  logic [7:0]  paddr, h_ext, h_en, ph_pin_in, ph_drain_sel, ph_pullup;
  logic [7:0]  ph_pulldown, ph_input_gate;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ext_irq_line;
  logic [3:0]  i_ext, i_en, pi_pin_in, pi_pin_out, pi_pin_oe, pi_pullup;
  logic [3:0]  pi_pulldown, pi_analog;
  int          n_errors, checks;
  logic [7:0]  offs [11] = '{OFF_PI_VALUE, OFF_PI_OE, OFF_PI_OD, OFF_PI_PU,
    OFF_PI_PD, OFF_PI_IE, OFF_PH_FSEL, OFF_PH_OD, OFF_PH_PU, OFF_PH_PD,
    OFF_PH_IE};
  logic [31:0] mask [11] = '{32'h0000_000f, 32'h0000_000f, 32'h0000_000f,
    32'h0000_000f, 32'h0000_000f, 32'h0000_000f, 32'h0000_0007,
    32'h0000_00ff, 32'h0000_00ff, 32'h0000_00ff, 32'h0000_00ff};

  gph_port_cfg gph_port_cfg_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_mode,
    .standby_pin_drive_keep, .ph_pin_in, .ph_drain_sel, .ph_pullup,
    .ph_pulldown, .ph_input_gate, .ext_irq_line, .pi_pin_in, .pi_pin_out,
    .pi_pin_oe, .pi_pullup, .pi_pulldown, .pi_analog);
  gph_pin_model gph_pin_model_i (.pclk, .h_ext, .h_ext_en(h_en),
    .h_pu(ph_pullup), .h_pd(ph_pulldown), .i_ext, .i_ext_en(i_en),
    .i_out(pi_pin_out), .i_oe(pi_pin_oe), .i_pu(pi_pullup),
    .i_pd(pi_pulldown), .h_pin(ph_pin_in), .i_pin(pi_pin_in));

  // Free-running clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Watchdog
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end

  // Test sequence
  initial
  begin
    {n_errors, checks} = '0;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {stop_mode, standby_pin_drive_keep, h_ext, h_en, i_ext, i_en} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then all-ones write and masked readback
    for (int k = 0; k < 11; k++)
    begin
      apb(1'b0, offs[k], 32'h0);
      check(rd, 32'h0);
      apb(1'b1, offs[k], 32'hffff_ffff);
    end
    for (int k = 0; k < 11; k++)
    begin
      apb(1'b0, offs[k], 32'h0);
      check(rd, mask[k]);
    end
    check(32'({pready, err}), 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
    @(negedge pclk);
    check({ph_drain_sel, ph_pullup, ph_pulldown, ph_input_gate},
          32'hffff_ffff);
    check(32'({pi_pin_out, pi_pin_oe, pi_pullup, pi_pulldown}),
          32'h0000_f0ff);
    check(32'(pi_analog), 32'h0000_000f);
    // Stop mode: selected lines stay armed, port I drive stops
    @(posedge pclk);
    stop_mode <= 1'b1;
    @(negedge pclk);
    check(32'(ext_irq_line), 32'h0000_0007);
    check(32'({pi_pin_oe, pi_pullup, pi_pulldown}), 32'h0);
    apb(1'b1, OFF_PH_FSEL, 32'h0000_0002);
    @(negedge pclk);
    check(32'(ext_irq_line), 32'h0000_0002);
    @(posedge pclk);
    stop_mode <= 1'b0;
    @(negedge pclk);
    check(32'(ext_irq_line), 32'h0000_0007);
    // Port I mixed direction
    @(posedge pclk);
    i_en  <= 4'hc;
    i_ext <= 4'h8;
    apb(1'b1, OFF_PI_OD, 32'h0);
    apb(1'b1, OFF_PI_VALUE, 32'h0000_0005);
    apb(1'b1, OFF_PI_OE, 32'h0000_0003);
    apb(1'b1, OFF_PI_IE, 32'h0000_000c);
    apb(1'b0, OFF_PI_VALUE, 32'h0);
    check(rd, 32'h0000_0009);
    check(32'({pi_pin_out, pi_pin_oe}), 32'h0000_0053);
    // Open-drain: a high data bit releases its pin
    apb(1'b1, OFF_PI_OD, 32'h0000_0003);
    @(negedge pclk);
    check(32'(pi_pin_oe), 32'h0000_0002);
    @(posedge pclk);
    stop_mode              <= 1'b1;
    standby_pin_drive_keep <= 1'b1;
    @(negedge pclk);
    check(32'(pi_pin_oe), 32'h0000_0002);
    // Reset in mid-run clears all registers and pad controls
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check({ph_drain_sel, ph_pullup, ph_pulldown, ph_input_gate},
          32'h0);
    check(32'({pi_pin_out, pi_pin_oe, pi_pullup, pi_pulldown}),
          32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_PI_IE, 32'h0);
    check(rd, 32'h0);
    close_out();
  end
endmodule : testbench
